/* File: rtl/timer_control_sync.v */
/*
 * control registers one and two of a 16-bit motor-control timer, with
 * update, one-shot, master output, dma timing and switchover logic.
 * assumes the counter datapath, channels and slave controller are outside
 * and feed their events in as single-cycle pulses on clk.
 */
// Summary of operation
// RULE1: writes need 16 or 32 bit width; reads of any width are served
// RULE2: dead-time clock is kernel clock divided by one, two or four
// RULE3: reload buffer select picks immediate or update-time reload load
// RULE4: edge mode follows direction; centre codes pick compare flag phase
// RULE5: software keeps alignment edge while the counter runs
// RULE6: direction bit is read-only in centre-aligned or encoder modes
// RULE7: single shot clears the run bit at the next update event
// RULE8: request source select limits update requests to over/underflow
// RULE9: update inhibit blocks update events but forced reinit still acts
// RULE10: counting needs the run bit except in gated mode; trigger mode may set it
// RULE11: debug halt freezes the counter when freeze select is set
// RULE12: outputs fall to idle levels when main output gate is low
// RULE13: idle level writes ignored while write protect level is nonzero
// RULE14: input one is channel one or xor of channels one to three
// RULE15: master output code 000 sends the forced update
// RULE16: code 001 sends counter run, gated trigger delayed one more cycle when msd
// RULE17: code 010 sends the update event
// RULE18: code 011 pulses on every channel one match flag set
// RULE19: codes 100 to 111 send channel reference waves one to four
// RULE20: channel dma on channel event or on update event
// RULE21: switchover on generate bit, also sync_in rise when selected
// RULE22: preloaded channel control bits apply at the switchover event
// RULE23: master slave delay aligns sync_in effect with downstream
// RULE24: reserved bits read zero; registers reset to zero
`timescale 1ns/10ps
`default_nettype none
`include "timer_control_map.vh"

module timer_control_sync (
    // clock and reset
    input wire clk,
    input wire reset,
    // register port
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [3:0] reg_byte_en,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata_q,
    output reg reg_err_q,
    // counter datapath events
    input wire counter_wrap,
    input wire force_update_bit,
    input wire slave_update,
    input wire slave_reinit,
    output reg update_event_q,
    output reg update_request_q,
    output reg counter_reinit_q,
    output reg count_step_q,
    output reg count_down_q,
    output reg reload_immediate_q,
    output reg [1:0] compare_flag_phase_q,
    // slave controller and debug
    input wire [2:0] slave_mode,
    input wire master_slave_delay,
    input wire sync_in,
    input wire core_halted,
    input wire halt_freeze_select,
    input wire prescaler_tick,
    input wire counter_dir_hw,
    output reg dts_tick_q,
    // channels and outputs
    input wire main_output_gate,
    input wire [1:0] write_protect_level,
    input wire [6:0] channel_drive,
    input wire [2:0] channel_pins,
    input wire channel1_match_set,
    input wire [3:0] channel_reference_wave,
    input wire [3:0] channel_event,
    output reg [6:0] channel_out_q,
    output reg timer_input1_q,
    output reg [3:0] channel_dma_q,
    // preloaded channel control
    input wire switchover_generate,
    input wire [15:0] channel_ctrl_written,
    output reg [15:0] channel_ctrl_active_q,
    output reg switchover_q,
    // master trigger
    output reg sync_out_q
);

parameter DEADTIME_CYCLES = 4;

reg [15:0] ctrl_one_q;
reg [15:0] ctrl_two_q;
reg sync_in_q;
reg sync_in_dly_q;
reg [7:0] dead_cnt_q;
wire dts_tick;
wire wr_ok;
wire hit_one;
wire hit_two;
wire run;
wire [1:0] align;
wire [2:0] master_output_select;
wire centre_or_enc;
wire gated_run;
wire trig_start;
wire sync_in_eff;
wire sync_rise;
wire upd_src;
wire upd_fire;
wire switchover;
wire [15:0] one_wmask;
wire [15:0] two_wmask;
wire [15:0] one_next;
wire [15:0] two_next;

// ----------------------------------------------------------------------
// decode
// ----------------------------------------------------------------------
assign hit_one = (reg_addr == `OFS_CONTROL_ONE);
assign hit_two = (reg_addr == `OFS_CONTROL_TWO);
// byte writes are not honoured; both low lanes must be enabled
assign wr_ok = reg_wr & (&reg_byte_en[1:0]); // see RULE1
assign run = ctrl_one_q[`C1_RUN];
assign align = ctrl_one_q[`C1_ALIGN_HI:`C1_ALIGN_LO];
assign master_output_select = ctrl_two_q[`C2_MMS_HI:`C2_MMS_LO];
assign centre_or_enc = (align != `ALIGN_EDGE) ||
    ((slave_mode >= `SLV_ENC1) && (slave_mode <= `SLV_ENC3)); // see RULE6

// sync_in edge, optionally held one extra cycle to align with slaves
assign sync_in_eff = master_slave_delay ? sync_in_dly_q : sync_in_q;
assign sync_rise = sync_in & ~sync_in_q;
assign gated_run = (slave_mode == `SLV_GATED) & sync_in_eff; // see RULE16
assign trig_start = (slave_mode == `SLV_TRIG) &
    (master_slave_delay ? (sync_in_q & ~sync_in_dly_q) : sync_rise);

// update sources, inhibited as a whole by update_inhibit
assign upd_src = counter_wrap | force_update_bit | slave_update;
assign upd_fire = upd_src & ~ctrl_one_q[`C1_INHIBIT]; // see RULE9

// switchover event for preloaded channel control
assign switchover = switchover_generate |
    (ctrl_two_q[`C2_SWUPD] & sync_rise); // see RULE21

// write masks: direction locked, idle levels locked by protect level
assign one_wmask = `C1_WMASK & ~(centre_or_enc ? `C1_DIR_MASK : 16'h0000);
assign two_wmask = `C2_WMASK |
    ((write_protect_level == 2'h0) ? `C2_IDLE_MASK : 16'h0000); // see RULE13
assign one_next = (ctrl_one_q & ~one_wmask) | (reg_wdata & one_wmask);
assign two_next = (ctrl_two_q & ~two_wmask) | (reg_wdata & two_wmask);

// ----------------------------------------------------------------------
// control registers
// ----------------------------------------------------------------------
// hardware clearing of the run bit wins over a software write
always @(posedge clk or posedge reset) begin
    if (reset) begin
        ctrl_one_q <= `REG_RESET; // see RULE24
        ctrl_two_q <= `REG_RESET;
    end else begin
        if (wr_ok && hit_one)
            ctrl_one_q <= one_next;
        else if (trig_start && !run)
            ctrl_one_q[`C1_RUN] <= 1'b1; // see RULE10
        if (centre_or_enc)
            ctrl_one_q[`C1_DIR] <= counter_dir_hw; // see RULE6
        if (upd_fire && ctrl_one_q[`C1_SHOT])
            ctrl_one_q[`C1_RUN] <= 1'b0; // see RULE7
        if (wr_ok && hit_two)
            ctrl_two_q <= two_next;
    end
end

// ----------------------------------------------------------------------
// read port
// ----------------------------------------------------------------------
always @(posedge clk or posedge reset) begin
    if (reset) begin
        reg_rdata_q <= 16'h0000;
        reg_err_q <= 1'b0;
    end else begin
        reg_err_q <= (reg_wr & ~wr_ok) |
            ((reg_wr | reg_rd) & ~hit_one & ~hit_two);
        if (reg_rd && hit_one)
            reg_rdata_q <= ctrl_one_q & `C1_WMASK; // see RULE24
        else if (reg_rd && hit_two)
            reg_rdata_q <= ctrl_two_q & (`C2_WMASK | `C2_IDLE_MASK);
        else if (reg_rd)
            reg_rdata_q <= 16'h0000;
    end
end

// ----------------------------------------------------------------------
// time base control
// ----------------------------------------------------------------------
always @(posedge clk or posedge reset) begin
    if (reset) begin
        update_event_q <= 1'b0;
        update_request_q <= 1'b0;
        counter_reinit_q <= 1'b0;
        count_step_q <= 1'b0;
        count_down_q <= 1'b0;
        reload_immediate_q <= 1'b1;
        compare_flag_phase_q <= 2'h0;
        sync_in_q <= 1'b0;
        sync_in_dly_q <= 1'b0;
    end else begin
        sync_in_q <= sync_in;
        sync_in_dly_q <= sync_in_q; // see RULE23
        update_event_q <= upd_fire;
        // narrowed request set when source select is high
        update_request_q <= ctrl_one_q[`C1_URS] ?
            (counter_wrap & ~ctrl_one_q[`C1_INHIBIT]) : upd_fire; // see RULE8
        counter_reinit_q <= force_update_bit | slave_reinit; // see RULE9
        // halted core freezes stepping only when freeze is selected
        count_step_q <= (run | gated_run) & prescaler_tick &
            ~(core_halted & halt_freeze_select); // see RULE10 RULE11
        count_down_q <= (align == `ALIGN_EDGE) ?
            ctrl_one_q[`C1_DIR] : counter_dir_hw; // see RULE4
        reload_immediate_q <= ~ctrl_one_q[`C1_RELOAD]; // see RULE3
        case (align)
            `ALIGN_DOWN: compare_flag_phase_q <= 2'h1; // see RULE4
            `ALIGN_UP: compare_flag_phase_q <= 2'h2;
            `ALIGN_BOTH: compare_flag_phase_q <= 2'h3;
            default: compare_flag_phase_q <= 2'h3;
        endcase
    end
end

// ----------------------------------------------------------------------
// channel side: idle levels, input select, dma timing, switchover
// ----------------------------------------------------------------------
always @(posedge clk or posedge reset) begin
    if (reset) begin
        dead_cnt_q <= 8'h00;
        channel_out_q <= 7'h00;
        timer_input1_q <= 1'b0;
        channel_dma_q <= 4'h0;
        channel_ctrl_active_q <= 16'h0000;
        switchover_q <= 1'b0;
    end else begin
        // gate off: wait dead-time in filter clock periods, then idle
        if (main_output_gate) begin
            dead_cnt_q <= 8'h00;
            channel_out_q <= channel_drive;
        end else if (dead_cnt_q < DEADTIME_CYCLES[7:0]) begin
            if (dts_tick)
                dead_cnt_q <= dead_cnt_q + 8'h01;
            // main output of channel four has no partner, goes at once
            channel_out_q[6] <= ctrl_two_q[`C2_IDLE_HI]; // see RULE12
        end else begin
            channel_out_q <= ctrl_two_q[`C2_IDLE_HI:`C2_IDLE_LO];
        end
        timer_input1_q <= ctrl_two_q[`C2_XOR] ?
            ^channel_pins : channel_pins[0]; // see RULE14
        channel_dma_q <= ctrl_two_q[`C2_DMATIME] ?
            {4{update_event_q}} : channel_event; // see RULE20
        switchover_q <= switchover;
        if (!ctrl_two_q[`C2_PRELOAD] || switchover)
            channel_ctrl_active_q <= channel_ctrl_written; // see RULE22
    end
end

// ----------------------------------------------------------------------
// master trigger output
// ----------------------------------------------------------------------
always @(posedge clk or posedge reset) begin
    if (reset) begin
        sync_out_q <= 1'b0;
    end else begin
        case (master_output_select)
            `MMS_RESET: sync_out_q <= force_update_bit; // see RULE15
            `MMS_ENABLE: sync_out_q <= run | gated_run; // see RULE16
            `MMS_UPDATE: sync_out_q <= upd_fire; // see RULE17
            `MMS_PULSE: sync_out_q <= channel1_match_set; // see RULE18
            default: sync_out_q <= channel_reference_wave[master_output_select[1:0]]; // see RULE19
        endcase
    end
end

// mirror of the tick for the filter blocks outside; see RULE2
always @(posedge clk or posedge reset) begin
    if (reset)
        dts_tick_q <= 1'b0;
    else
        dts_tick_q <= dts_tick;
end

// ----------------------------------------------------------------------
// dead-time clock divider
// ----------------------------------------------------------------------
deadtime_divider u_div (
    .clk(clk),
    .reset(reset),
    .filter_clock_divide(ctrl_one_q[`C1_DIV_HI:`C1_DIV_LO]),
    .dts_tick_q(dts_tick)
);

endmodule // timer_control_sync
`default_nettype wire

/* File: pkg/timer_control_map.vh */
/*
 * register offsets, field positions and reset values of the two timer
 * control registers. assumes a 16-bit register port with byte strobes.
 */
`ifndef TIMER_CONTROL_MAP_VH
`define TIMER_CONTROL_MAP_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_CONTROL_ONE 8'h00
`define OFS_CONTROL_TWO 8'h04

// ----------------------------------------------------------------------
// control one fields
// ----------------------------------------------------------------------
`define C1_RUN 0
`define C1_INHIBIT 1
`define C1_URS 2
`define C1_SHOT 3
`define C1_DIR 4
`define C1_ALIGN_LO 5
`define C1_ALIGN_HI 6
`define C1_RELOAD 7
`define C1_DIV_LO 8
`define C1_DIV_HI 9
`define C1_WMASK 16'h03ff
`define C1_DIR_MASK 16'h0010

// ----------------------------------------------------------------------
// control two fields
// ----------------------------------------------------------------------
`define C2_PRELOAD 0
`define C2_SWUPD 2
`define C2_DMATIME 3
`define C2_MMS_LO 4
`define C2_MMS_HI 6
`define C2_XOR 7
`define C2_IDLE_LO 8
`define C2_IDLE_HI 14
`define C2_WMASK 16'h00fd
`define C2_IDLE_MASK 16'h7f00

`define REG_RESET 16'h0000

// ----------------------------------------------------------------------
// codes
// ----------------------------------------------------------------------
`define ALIGN_EDGE 2'h0
`define ALIGN_DOWN 2'h1
`define ALIGN_UP 2'h2
`define ALIGN_BOTH 2'h3
`define DIV_ONE 2'h0
`define DIV_TWO 2'h1
`define DIV_FOUR 2'h2
`define DIV_CNT_ONE 2'h0
`define DIV_CNT_TWO 2'h1
`define DIV_CNT_FOUR 2'h3
`define MMS_RESET 3'h0
`define MMS_ENABLE 3'h1
`define MMS_UPDATE 3'h2
`define MMS_PULSE 3'h3
`define MMS_REF1 3'h4
`define SLV_ENC1 3'h1
`define SLV_ENC3 3'h3
`define SLV_RESET 3'h4
`define SLV_GATED 3'h5
`define SLV_TRIG 3'h6

`endif

/* File: rtl/deadtime_divider.v */
/*
 * divider making the filter_deadtime_clock enable from the kernel clock.
 * assumes the division code is held stable by software between changes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "timer_control_map.vh"

module deadtime_divider (
    // clock and reset
    input wire clk,
    input wire reset,
    // division code and tick out
    input wire [1:0] filter_clock_divide,
    output reg dts_tick_q
);

reg [1:0] cnt_q;
reg [1:0] limit;

// ----------------------------------------------------------------------
// code to terminal count; reserved code treated as divide by four
// ----------------------------------------------------------------------
always @* begin
    case (filter_clock_divide)
        `DIV_ONE: limit = `DIV_CNT_ONE;
        `DIV_TWO: limit = `DIV_CNT_TWO;
        `DIV_FOUR: limit = `DIV_CNT_FOUR;
        default: limit = `DIV_CNT_FOUR;
    endcase
end

// free running counter, one tick per period
always @(posedge clk or posedge reset) begin
    if (reset) begin
        cnt_q <= 2'h0;
        dts_tick_q <= 1'b0;
    end else begin
        dts_tick_q <= (cnt_q >= limit); // see RULE2
        if (cnt_q >= limit)
            cnt_q <= 2'h0;
        else
            cnt_q <= cnt_q + 2'h1;
    end
end

endmodule // deadtime_divider
`default_nettype wire

/* File: test/timer_control_sync_monitor.sv */
/* checker for timer_control_sync: master output, dma, switchover,
 * input select, freeze and write refusal relations.
 * assumes one clock and an asynchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module timer_control_sync_monitor (
    // clock and reset
    input wire clk,
    input wire reset,
    // register write port
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [3:0] reg_byte_en,
    input wire [15:0] reg_wdata,
    input wire reg_err_q,
    // events and levels in
    input wire force_update_bit,
    input wire core_halted,
    input wire halt_freeze_select,
    input wire [2:0] channel_pins,
    input wire channel1_match_set,
    input wire [3:0] channel_reference_wave,
    input wire [3:0] channel_event,
    input wire switchover_generate,
    // outputs watched
    input wire count_step_q,
    input wire timer_input1_q,
    input wire [3:0] channel_dma_q,
    input wire switchover_q,
    input wire sync_out_q
);
default clocking @(posedge clk); endclocking
default disable iff (reset);
logic [15:0] c2_q;
logic ref_q;
logic pin_q;
// shadow of control two; hardware never alters the bits used here
always @(posedge clk or posedge reset) begin
    if (reset) begin
        c2_q <= 16'h0000;
        ref_q <= 1'b0;
        pin_q <= 1'b0;
    end else begin
        if (reg_wr && reg_byte_en[1:0] == 2'h3 && reg_addr == 8'h04)
            c2_q <= reg_wdata;
        ref_q <= channel_reference_wave[c2_q[5:4]];
        pin_q <= c2_q[7] ? ^channel_pins : channel_pins[0];
    end
end
a_byte_write_err: assert property (
    reg_wr && reg_byte_en[1:0] != 2'h3 |=> reg_err_q)
    else $error("byte write not flagged");
a_halt_freeze: assert property (
    core_halted && halt_freeze_select |=> !count_step_q)
    else $error("count step while frozen");
a_xor_input: assert property (
    timer_input1_q == pin_q) else $error("input one select wrong");
a_mms_force: assert property (
    c2_q[6:4] == 3'h0 && force_update_bit |=> sync_out_q)
    else $error("forced update missing on sync_out");
a_mms_pulse: assert property (
    c2_q[6:4] == 3'h3 && channel1_match_set |=> sync_out_q)
    else $error("match pulse missing on sync_out");
a_mms_ref: assert property (
    $past(c2_q[6]) |-> sync_out_q == ref_q)
    else $error("sync_out not the selected wave");
a_dma_event: assert property (
    !c2_q[3] && channel_event[0] |=> channel_dma_q[0])
    else $error("channel dma missing");
a_switch_gen: assert property (
    switchover_generate |=> switchover_q)
    else $error("switchover missing");
c_match: cover property (c2_q[6:4] == 3'h3 && channel1_match_set);
c_xor: cover property (c2_q[7] && ^channel_pins);
c_switch: cover property (switchover_generate);
endmodule // timer_control_sync_monitor
bind timer_control_sync timer_control_sync_monitor mon (.clk, .reset,
    .reg_addr, .reg_wr, .reg_byte_en, .reg_wdata, .reg_err_q,
    .force_update_bit, .core_halted, .halt_freeze_select, .channel_pins,
    .channel1_match_set, .channel_reference_wave, .channel_event,
    .switchover_generate, .count_step_q, .timer_input1_q, .channel_dma_q,
    .switchover_q, .sync_out_q);
`default_nettype wire

/* File: test/sync_peer_model.sv */
/* neighbouring timer on the trigger lines: raises sync_in on request
 * and counts rising edges of sync_out. assumes clk and async reset. */
`timescale 1ns/10ps
`default_nettype none
module sync_peer_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // trigger lines
    input wire logic fire,
    input wire logic sync_out_q,
    output logic sync_in,
    output var int rises
);
logic [1:0] hold_q;
logic last_q;
// trigger held several cycles so a slow edge detector still sees it
always @(posedge clk or posedge reset) begin
    if (reset) begin
        hold_q <= 2'h0;
        last_q <= 1'b0;
        sync_in <= 1'b0;
        rises <= 0;
    end else begin
        hold_q <= fire ? 2'h3 : hold_q - {1'b0, hold_q != 2'h0};
        sync_in <= fire || hold_q != 2'h0;
        last_q <= sync_out_q;
        rises <= rises + (sync_out_q && !last_q);
    end
end
endmodule // sync_peer_model
`default_nettype wire

/* File: test/test_timer_control_sync.sv */
/* bench for timer_control_sync: registers, update logic, master output,
 * idle outputs, dma and switchover. assumes the peer model and checker. */
`timescale 1ns/10ps
`default_nettype none
module test_timer_control_sync;
logic clk, reset, reg_wr, reg_rd, sync_in, fire;
logic master_slave_delay, core_halted, halt_freeze_select, prescaler_tick;
logic counter_dir_hw, main_output_gate, reg_err_q, update_event_q;
logic update_request_q, counter_reinit_q, count_step_q, count_down_q;
logic reload_immediate_q, dts_tick_q, timer_input1_q, switchover_q;
logic sync_out_q;
logic [1:0] write_protect_level, compare_flag_phase_q;
logic [2:0] slave_mode, channel_pins;
logic [3:0] reg_byte_en, channel_reference_wave, channel_dma_q;
logic [6:0] channel_drive, channel_out_q;
logic [7:0] reg_addr;
logic [11:0] pl;
logic [15:0] reg_wdata, reg_rdata_q, channel_ctrl_written;
logic [15:0] channel_ctrl_active_q;
int num_errors = 0, n_tests = 0, cyc = 0, rises, n;
// event pulses: 0 wrap, 1 force, 4 match, 5 switchover, 11:8 channels
timer_control_sync #(.DEADTIME_CYCLES(1)) uut (.clk, .reset, .reg_addr,
    .reg_wr, .reg_rd, .reg_byte_en, .reg_wdata, .reg_rdata_q, .reg_err_q,
    .counter_wrap(pl[0]), .force_update_bit(pl[1]), .slave_update(pl[2]),
    .slave_reinit(pl[3]), .update_event_q, .update_request_q,
    .counter_reinit_q, .count_step_q, .count_down_q, .reload_immediate_q,
    .compare_flag_phase_q, .slave_mode, .master_slave_delay, .sync_in,
    .core_halted, .halt_freeze_select, .prescaler_tick, .counter_dir_hw,
    .dts_tick_q, .main_output_gate, .write_protect_level, .channel_drive,
    .channel_pins, .channel1_match_set(pl[4]), .channel_reference_wave,
    .channel_event(pl[11:8]), .channel_out_q, .timer_input1_q,
    .channel_dma_q, .switchover_generate(pl[5]), .channel_ctrl_written,
    .channel_ctrl_active_q, .switchover_q, .sync_out_q);
sync_peer_model peer (.clk, .reset, .fire, .sync_out_q, .sync_in, .rises);
initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
end
// hang guard: the whole run needs well under a thousand cycles
always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
        num_errors++;
        wrap_up;
    end
end
task tick(input int k);
    repeat (k) @(posedge clk);
    #2;
endtask
task pulse(input logic [11:0] m);
    tick(1);
    pl = m;
    tick(1);
    pl = 12'h000;
endtask
task wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] b);
    tick(1);
    reg_addr = a;
    reg_wdata = d;
    reg_byte_en = b;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
endtask
task chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
        num_errors++;
        $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
endtask
task rdc(input logic [7:0] a, input logic [15:0] e);
    tick(1);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk(reg_rdata_q, e);
endtask
task t_regs;
    rdc(8'h00, 16'h0000);
    chk(reload_immediate_q, 16'h1);
    wr(8'h00, 16'hfe86, 4'h3);
    rdc(8'h00, 16'h0286);
    chk(reload_immediate_q, 16'h0);
    wr(8'h00, 16'h0000, 4'h1);
    chk(reg_err_q, 16'h1);
    rdc(8'h00, 16'h0286);
    wr(8'h08, 16'h0000, 4'h3);
    chk(reg_err_q, 16'h1);
    wr(8'h04, 16'hffff, 4'h3);
    rdc(8'h04, 16'h7ffd);
    write_protect_level = 2'h1;
    wr(8'h04, 16'h0000, 4'h3);
    rdc(8'h04, 16'h7f00);
    write_protect_level = 2'h0;
    wr(8'h04, 16'h0000, 4'h3);
    $display("register test done");
endtask
task t_upd;
    wr(8'h00, 16'h0009, 4'h3);
    pulse(12'h001);
    chk(update_event_q, 16'h1);
    rdc(8'h00, 16'h0008);
    wr(8'h00, 16'h0004, 4'h3);
    pulse(12'h002);
    chk({update_event_q, update_request_q}, 16'h2);
    pulse(12'h004);
    chk({update_event_q, update_request_q}, 16'h2);
    pulse(12'h001);
    chk(update_request_q, 16'h1);
    wr(8'h00, 16'h0002, 4'h3);
    pulse(12'h002);
    chk({update_event_q, counter_reinit_q}, 16'h1);
    pulse(12'h008);
    chk({update_event_q, counter_reinit_q}, 16'h1);
    $display("update test done");
endtask
task t_mode;
    // run stays clear while alignment moves off edge mode
    for (int c = 0; c < 4; c++) begin
        wr(8'h00, {9'h0, c[1:0], 5'h0}, 4'h3);
        tick(1);
        chk(compare_flag_phase_q, c == 0 ? 2'h3 : c[1:0]);
    end
    wr(8'h00, 16'h0070, 4'h3);
    rdc(8'h00, 16'h0060);
    // direction stays locked until the edge mode write has landed
    wr(8'h00, 16'h0000, 4'h3);
    wr(8'h00, 16'h0010, 4'h3);
    tick(1);
    chk(count_down_q, 16'h1);
    for (int c = 0; c < 3; c++) begin
        wr(8'h00, {6'h0, c[1:0], 8'h0}, 4'h3);
        tick(4);
        n = 0;
        repeat (16) begin
            n += dts_tick_q === 1'b1;
            tick(1);
        end
        chk(n[15:0], 16'(16 >> c));
    end
    wr(8'h00, 16'h0000, 4'h3);
    $display("mode test done");
endtask
task t_trig;
    wr(8'h04, 16'h0010, 4'h3);
    slave_mode = 3'h6;
    master_slave_delay = 1'b1;
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
    tick(2);
    chk(sync_out_q, 16'h0);
    tick(2);
    rdc(8'h00, 16'h0001);
    chk(sync_out_q, 16'h1);
    core_halted = 1'b1;
    halt_freeze_select = 1'b1;
    tick(2);
    chk(count_step_q, 16'h0);
    halt_freeze_select = 1'b0;
    tick(2);
    chk(count_step_q, 16'h1);
    core_halted = 1'b0;
    slave_mode = 3'h0;
    master_slave_delay = 1'b0;
    wr(8'h00, 16'h0000, 4'h3);
    $display("trigger test done");
endtask
task t_mms;
    for (int m = 4; m < 8; m++) begin
        wr(8'h04, {9'h0, m[2:0], 4'h0}, 4'h3);
        channel_reference_wave = 4'(1 << (m - 4));
        tick(2);
        chk(sync_out_q, 16'h1);
        channel_reference_wave = ~channel_reference_wave;
        tick(2);
        chk(sync_out_q, 16'h0);
    end
    wr(8'h04, 16'h0030, 4'h3);
    pulse(12'h010);
    chk(sync_out_q, 16'h1);
    wr(8'h04, 16'h0020, 4'h3);
    n = rises;
    repeat (3) begin
        pulse(12'h001);
        tick(3);
    end
    chk(16'(rises - n), 16'h3);
    $display("master output test done");
endtask
task t_out;
    wr(8'h04, 16'h5580, 4'h3);
    channel_drive = 7'h2a;
    channel_pins = 3'h3;
    main_output_gate = 1'b0;
    tick(8);
    chk(channel_out_q, 16'h55);
    chk(timer_input1_q, 16'h0);
    main_output_gate = 1'b1;
    wr(8'h04, 16'h0008, 4'h3);
    pulse(12'hf00);
    chk(channel_dma_q, 16'h0);
    pulse(12'h001);
    tick(1);
    chk(channel_dma_q, 16'hf);
    wr(8'h04, 16'h0000, 4'h3);
    pulse(12'hf00);
    chk(channel_dma_q, 16'hf);
    $display("output test done");
endtask
task t_pre;
    wr(8'h04, 16'h0001, 4'h3);
    channel_ctrl_written = 16'h1234;
    tick(2);
    chk(channel_ctrl_active_q, 16'h0000);
    pulse(12'h020);
    tick(1);
    chk(channel_ctrl_active_q, 16'h1234);
    wr(8'h04, 16'h0005, 4'h3);
    channel_ctrl_written = 16'habcd;
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
    tick(4);
    chk(channel_ctrl_active_q, 16'habcd);
    $display("switchover test done");
endtask
task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
endtask
initial begin
    {reg_wr, reg_rd, fire, pl, reg_addr, reg_byte_en, reg_wdata} = '0;
    {slave_mode, master_slave_delay, core_halted, halt_freeze_select} = '0;
    {counter_dir_hw, write_protect_level, channel_drive, channel_pins} = '0;
    {channel_reference_wave, channel_ctrl_written} = '0;
    {prescaler_tick, main_output_gate, reset} = 3'h7;
    repeat (20) @(posedge clk);
    #2 reset = 1'b0;
    tick(1);
    t_regs;
    t_upd;
    t_mode;
    t_trig;
    t_mms;
    t_out;
    t_pre;
    wrap_up;
end
endmodule // test_timer_control_sync
`default_nettype wire
